// ### shared/porwd_map.svh
// Timing counts and thresholds for the reset timer and window watchdog
`ifndef PORWD_MAP_SVH
`define PORWD_MAP_SVH
`define PORWD_RST_CYCLES 7'h40
`define PORWD_DLY_CYCLES 7'h21
`define PORWD_WDL_CYCLES 7'h04
`define PORWD_WDU_CYCLES 7'h40
`define PORWD_HV_GOOD_MV 12'h47E
`define PORWD_LV_GOOD_MV 12'h226
// Service line low time; the device filter needs two agreeing samples
`define PORWD_SVC_LOW_CYCLES 2'h3
`endif

// ### shared/porwd_pkg.sv
// Types shared by both ends of the reset timer and watchdog
package porwd_pkg;
  typedef logic [6:0] porwd_cnt_t;
  typedef logic [11:0] porwd_mv_t;
  typedef enum logic [3:0] {
    PORWD_OFF = 4'h1,
    PORWD_DELAY = 4'h2,
    PORWD_WATCH = 4'h4,
    PORWD_FAULT = 4'h8
  } porwd_wd_t;
endpackage

// ### shared/porwd_if.sv
// Link between the device timing logic and the processor end
`timescale 1ns/1ps
interface porwd_if;
  logic hvResetOe;
  logic lvResetOe;
  logic faultOe;
  logic hvChannelResetN;
  logic lvChannelResetN;
  logic watchdogFaultN;
  logic watchdogEnableN;
  logic watchdogServiceIn;
  // Open drain wires with weak pull-up: low only while an enable is low
  assign hvChannelResetN = hvResetOe;
  assign lvChannelResetN = lvResetOe;
  assign watchdogFaultN = faultOe;
  modport dev (
    output hvResetOe,
    output lvResetOe,
    output faultOe,
    input hvChannelResetN,
    input lvChannelResetN,
    input watchdogEnableN,
    input watchdogServiceIn
  );
  modport host (
    input hvChannelResetN,
    input lvChannelResetN,
    input watchdogFaultN,
    output watchdogEnableN,
    output watchdogServiceIn
  );
endinterface

// ### hdl/porwd_device.sv
// Device end: power-on reset timers and window watchdog
// Operation
// - Comparators judge 1.15V and 550mV feedback
// - Comparators run continuously from power-up
// - Both reset timers share one oscillator
// - Reset timeout is 64 oscillator cycles
// - Good feedback starts timer, then releases reset
// - Reset outputs open drain, wired-OR capable
// - Watchdog works only while enabled
// - Both resets released starts watchdog oscillator
// - Initial 33 cycle delay ignores service
// - Only falling service edges count
// - Edges closer than 4 cycles fault
// - 64 cycles without edge faults
// - Fault output low for 64 reset cycles
// - Fault release restarts the ignore delay
// - Good edge restarts count, fault high
// - Reset oscillator idle while serviced correctly
// - Fault output open drain like resets
`timescale 1ns/1ps
`include "porwd_map.svh"
module porwd_device
  import porwd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Analogue feedback levels in millivolts
  input wire porwd_mv_t hvFeedback,
  input wire porwd_mv_t lvFeedback,
  // Oscillator ticks
  input wire logic resetPeriodOsc,
  input wire logic watchdogPeriodOsc,
  // Link to processor
  porwd_if.dev link,
  // Status
  output logic resetOscRunning,
  output logic watchdogOscRunning
);
  typedef struct packed {
    porwd_cnt_t hvCnt;
    porwd_cnt_t lvCnt;
    logic hvRel;
    logic lvRel;
    porwd_wd_t wd;
    porwd_cnt_t wdCnt;
    porwd_cnt_t faultCnt;
    logic [2:0] svcSync;
    logic svcLevel;
    logic [2:0] enSync;
  } porwd_dev_st_t;

  porwd_dev_st_t st_q;
  porwd_dev_st_t st_d;
  logic hvGood;
  logic lvGood;
  logic svcFall;
  logic wdOn;

  // Comparators always active; no enable gate at all
  assign hvGood = hvFeedback >= `PORWD_HV_GOOD_MV;
  assign lvGood = lvFeedback >= `PORWD_LV_GOOD_MV;
  // Filtered service level and enable (active low)
  assign svcFall = st_q.svcLevel && (st_q.svcSync[2:1] == 2'b00);
  assign wdOn = (st_q.enSync[2:1] == 2'b00);

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.svcSync = {st_q.svcSync[1:0], link.watchdogServiceIn};
    st_d.enSync = {st_q.enSync[1:0], link.watchdogEnableN};
    // Level updates only when the second and third stages agree
    if (st_q.svcSync[2] == st_q.svcSync[1]) begin
      st_d.svcLevel = st_q.svcSync[2];
    end
    // Channel timers on the shared reset oscillator
    if (!hvGood) begin
      st_d.hvCnt = '0;
      st_d.hvRel = 1'b0;
    end else if (!st_q.hvRel && resetPeriodOsc) begin
      st_d.hvCnt = st_q.hvCnt + 7'h01;
      if (st_q.hvCnt == `PORWD_RST_CYCLES - 7'h01) begin
        st_d.hvRel = 1'b1;
      end
    end
    if (!lvGood) begin
      st_d.lvCnt = '0;
      st_d.lvRel = 1'b0;
    end else if (!st_q.lvRel && resetPeriodOsc) begin
      st_d.lvCnt = st_q.lvCnt + 7'h01;
      if (st_q.lvCnt == `PORWD_RST_CYCLES - 7'h01) begin
        st_d.lvRel = 1'b1;
      end
    end
    // Watchdog sequence
    if (!(st_q.hvRel && st_q.lvRel) || !wdOn) begin
      st_d.wd = PORWD_OFF;
      st_d.wdCnt = '0;
      st_d.faultCnt = '0;
    end else begin
      case (st_q.wd)
        PORWD_OFF: begin
          st_d.wd = PORWD_DELAY;
          st_d.wdCnt = '0;
        end
        PORWD_DELAY: begin
          // Service input ignored here
          if (watchdogPeriodOsc) begin
            st_d.wdCnt = st_q.wdCnt + 7'h01;
            if (st_q.wdCnt == `PORWD_DLY_CYCLES - 7'h01) begin
              st_d.wd = PORWD_WATCH;
              st_d.wdCnt = '0;
            end
          end
        end
        PORWD_WATCH: begin
          if (svcFall) begin
            if (st_q.wdCnt < `PORWD_WDL_CYCLES) begin
              st_d.wd = PORWD_FAULT;
              st_d.faultCnt = '0;
            end else begin
              st_d.wdCnt = '0;
            end
          end else if (watchdogPeriodOsc) begin
            st_d.wdCnt = st_q.wdCnt + 7'h01;
            if (st_q.wdCnt == `PORWD_WDU_CYCLES - 7'h01) begin
              st_d.wd = PORWD_FAULT;
              st_d.faultCnt = '0;
            end
          end
        end
        PORWD_FAULT: begin
          if (resetPeriodOsc) begin
            st_d.faultCnt = st_q.faultCnt + 7'h01;
            if (st_q.faultCnt == `PORWD_RST_CYCLES - 7'h01) begin
              st_d.wd = PORWD_DELAY;
              st_d.wdCnt = '0;
            end
          end
        end
        default: begin
          st_d.wd = PORWD_OFF;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{hvCnt: '0, lvCnt: '0, hvRel: 1'b0, lvRel: 1'b0, wd: PORWD_OFF,
                wdCnt: '0, faultCnt: '0, svcSync: 3'h7, svcLevel: 1'b1,
                enSync: 3'h7};
    end else begin
      st_q <= st_d;
    end
  end

  // Open drain pins: enable low pulls the wire low
  assign link.hvResetOe = st_q.hvRel;
  assign link.lvResetOe = st_q.lvRel;
  assign link.faultOe = (st_q.wd != PORWD_FAULT);
  // Reset oscillator runs only to time a reset or a fault
  assign resetOscRunning = (hvGood && !st_q.hvRel) || (lvGood && !st_q.lvRel)
                           || (st_q.wd == PORWD_FAULT);
  assign watchdogOscRunning = (st_q.wd == PORWD_DELAY) || (st_q.wd == PORWD_WATCH);
endmodule

// ### hdl/porwd_host.sv
// Processor end: watchdog enable, service edges and reset observation
`timescale 1ns/1ps
`include "porwd_map.svh"
module porwd_host
  import porwd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link to device
  porwd_if.host link,
  // User side
  input wire logic enableWatchdog,
  input wire logic serviceReq,
  output logic serviceAccepted,
  output logic systemInReset,
  output logic faultSeen
);
  typedef struct packed {
    logic svc;
    logic [1:0] lowCnt;
    logic [2:0] rstSync;
    logic [2:0] fltSync;
  } porwd_host_st_t;

  porwd_host_st_t st_q;
  porwd_host_st_t st_d;

  // Falling edge on request: pull line low on each accepted request
  assign serviceAccepted = serviceReq && st_q.svc;
  always_comb begin
    st_d = st_q;
    st_d.rstSync = {st_q.rstSync[1:0], link.hvChannelResetN & link.lvChannelResetN};
    st_d.fltSync = {st_q.fltSync[1:0], link.watchdogFaultN};
    // A request pulls the line low for three cycles: a one-cycle pulse
    // would slip through the device's agreeing-stage filter unseen.
    // User must keep requests far enough apart, else the device faults.
    if (serviceAccepted) begin
      st_d.svc = 1'b0;
      st_d.lowCnt = `PORWD_SVC_LOW_CYCLES;
    end else if (!st_q.svc) begin
      st_d.lowCnt = st_q.lowCnt - 2'h1;
      if (st_q.lowCnt == 2'h1) begin
        st_d.svc = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{svc: 1'b1, lowCnt: 2'h0, rstSync: 3'h0, fltSync: 3'h7};
    end else begin
      st_q <= st_d;
    end
  end

  assign link.watchdogEnableN = !enableWatchdog;
  assign link.watchdogServiceIn = st_q.svc;
  // Wired-OR of both resets seen as one system reset
  assign systemInReset = !(st_q.rstSync[2] && st_q.rstSync[1]);
  assign faultSeen = !(st_q.fltSync[2] || st_q.fltSync[1]);
endmodule

// ### verification/porwd_asserts.sv
// Checker watching the link between device and processor ends
`timescale 1ns/1ps
module porwd_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link signals
  input wire logic hvResetOe,
  input wire logic lvResetOe,
  input wire logic faultOe,
  input wire logic watchdogEnableN,
  input wire logic watchdogServiceIn
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Ticks are at least a cycle apart, so 8 cycles is a safe lower bound
  sequence faultHeld; !faultOe[*8]; endsequence
  sequence faultQuiet; faultOe[*8]; endsequence
  sequence svcLowPulse; !watchdogServiceIn[*3] ##1 watchdogServiceIn; endsequence
  after_reset_a: assert property (!$past(rst_b) |-> !hvResetOe && !lvResetOe && faultOe)
    else $error("outputs wrong after reset");
  hv_release_a: assert property ($rose(hvResetOe) |-> !$past(hvResetOe, 8))
    else $error("hv reset released early");
  lv_release_a: assert property ($rose(lvResetOe) |-> !$past(lvResetOe, 8))
    else $error("lv reset released early");
  fault_cause_a: assert property ($fell(faultOe) |->
    $past(hvResetOe) && $past(lvResetOe) && !$past(watchdogEnableN))
    else $error("fault while watchdog off");
  fault_hold_a: assert property ($fell(faultOe) |-> faultHeld)
    else $error("fault pulse too short");
  start_delay_a: assert property ($rose(hvResetOe && lvResetOe) |-> faultQuiet)
    else $error("fault inside first delay");
  rerun_delay_a: assert property ($rose(faultOe) |-> faultQuiet)
    else $error("fault inside restarted delay");
  service_pulse_a: assert property ($fell(watchdogServiceIn) |-> svcLowPulse)
    else $error("service line held low");
endmodule

// ### verification/test_power_on_reset_window_watchdog.sv
// Self-checking bench joining the device end and the processor end
`timescale 1ns/1ps
module test_power_on_reset_window_watchdog
  import porwd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  porwd_mv_t hvFeedback = 12'h47E;
  porwd_mv_t lvFeedback = 12'h225;
  logic resetPeriodOsc = 1'b0;
  logic watchdogPeriodOsc = 1'b0;
  logic enableWatchdog = 1'b1;
  logic serviceReq = 1'b0;
  logic resetOscRunning, watchdogOscRunning, serviceAccepted, systemInReset, faultSeen;
  int bad_count = 0;
  int samples_checked = 0;
  porwd_if link ();
  porwd_device porwd_device_i (.clk_sys, .rst_b, .hvFeedback, .lvFeedback, .resetPeriodOsc,
    .watchdogPeriodOsc, .link(link.dev), .resetOscRunning, .watchdogOscRunning);
  porwd_host porwd_host_i (.clk_sys, .rst_b, .link(link.host), .enableWatchdog, .serviceReq,
    .serviceAccepted, .systemInReset, .faultSeen);
  porwd_asserts porwd_asserts_i (.clk_sys, .rst_b, .hvResetOe(link.hvResetOe),
    .lvResetOe(link.lvResetOe), .faultOe(link.faultOe),
    .watchdogEnableN(link.watchdogEnableN), .watchdogServiceIn(link.watchdogServiceIn));
  always #2.5 clk_sys = ~clk_sys;
  // Ticks every other cycle: one count is two cycles, margins stay wide
  always @(posedge clk_sys) begin
    resetPeriodOsc <= #1 ~resetPeriodOsc;
    watchdogPeriodOsc <= #1 ~watchdogPeriodOsc;
  end
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic service();
    serviceReq = 1'b1;
    #1;
    check("accepted", 1'b1, serviceAccepted);
    tick(1);
    serviceReq = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Low channel one millivolt short of good, then at the threshold
  task automatic power_up();
    tick(100);
    check("hv reset", 1'b0, link.hvChannelResetN);
    check("reset osc", 1'b1, resetOscRunning);
    tick(40);
    check("hv reset", 1'b1, link.hvChannelResetN);
    check("lv reset", 1'b0, link.lvChannelResetN);
    lvFeedback = 12'h226;
    tick(100);
    check("in reset", 1'b1, systemInReset);
    tick(45);
    check("in reset", 1'b0, systemInReset);
    $display("power up done");
  endtask
  // First edge falls inside the delay and is ignored; six edges outlast
  // the upper bound, so a missing count restart would fault
  task automatic good_service();
    repeat (6) begin
      tick(40);
      service();
      check("fault", 1'b0, faultSeen);
      check("wd osc", 1'b1, watchdogOscRunning);
      check("reset osc", 1'b0, resetOscRunning);
    end
    $display("good service done");
  endtask
  task automatic early_fault();
    tick(4);
    service();
    tick(10);
    check("fault", 1'b1, faultSeen);
    check("fault wire", 1'b0, link.watchdogFaultN);
    tick(100);
    check("fault wire", 1'b0, link.watchdogFaultN);
    tick(40);
    check("fault wire", 1'b1, link.watchdogFaultN);
    $display("early edge done");
  endtask
  task automatic late_fault();
    service();
    tick(150);
    check("fault wire", 1'b1, link.watchdogFaultN);
    tick(40);
    check("fault wire", 1'b0, link.watchdogFaultN);
    $display("late edge done");
  endtask
  task automatic off_and_loss();
    tick(120);
    enableWatchdog = 1'b0;
    tick(300);
    check("fault wire", 1'b1, link.watchdogFaultN);
    hvFeedback = 12'h47D;
    tick(3);
    check("hv reset", 1'b0, link.hvChannelResetN);
    hvFeedback = 12'h47E;
    tick(100);
    check("hv reset", 1'b0, link.hvChannelResetN);
    tick(40);
    check("hv reset", 1'b1, link.hvChannelResetN);
    $display("off and loss done");
  endtask
  initial begin
    tick(4);
    rst_b = 1'b1;
    power_up();
    good_service();
    early_fault();
    late_fault();
    off_and_loss();
    stop_test();
  end
  // Whole run is near 7 us; a hang is cut well after that
  initial begin
    #20us;
    bad_count++;
    stop_test();
  end
endmodule
